// *** toc_prescaler.sv ***
`timescale 1ns/1ps
`include "toc_regs.svh"
// Summary of operation
// RULE1 - First shared clock picks its tap from bits 3..0.
// RULE2 - Second shared clock picks its tap from bits 7..4.
// RULE3 - Third clock uses bits 9..8, offered to channels one and three only.
// RULE4 - Fourth clock uses bits 13..12, offered to channels one and three only.
// RULE5 - A four-bit code k gives the peripheral clock divided by 2^k.
// RULE6 - Third clock codes give division by 2, 4, 16 and 64.
// RULE7 - Fourth clock codes 00 and 01 give division by 256 and 1024.
// RULE8 - Fourth clock codes 10 and 11 give division by 4096 and 16384.
// RULE9 - Software changes clocks a or b only while their channels are stopped.
// RULE10 - Software changes clocks c or d only while channels one and three are stopped.
// RULE11 - The select register is written as one 16-bit access only.
// RULE12 - Reset clears the select register to zero.
// RULE13 - Each divided clock is a pulse one peripheral clock wide.
// RULE14 - Bits 15, 14, 11 and 10 stay zero.
// RULE15 - Software stops all channels before changing the peripheral clock source.
// RULE16 - No interrupts when undivided clock used with a zero data register.
// RULE17 - Software stops the unit when changing a channel clock or input edge.
// RULE18 - With the unit clock disabled, the select register stays cleared, writes ignored.
// RULE19 - One run-status bit per channel is readable in a status register.
module toc_prescaler
  import toc_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [23:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Channel side
  input wire logic [NUM_CH-1:0] CHANNEL_RUN_STATUS_I,
  output logic [15:0] PRESCALE_SELECT_REG_O,
  output logic UNIT_CLOCK_ENABLE_O,
  // Shared operation clock enables
  output logic SHARED_OP_CLOCK_A_O,
  output logic SHARED_OP_CLOCK_B_O,
  output logic SHARED_OP_CLOCK_C_O,
  output logic SHARED_OP_CLOCK_D_O
);

  // True when the low k bits of the counter are all ones
  function automatic logic tap_hit(input toc_count_t cnt, input logic [3:0] k);
    toc_count_t mask;
    mask = toc_count_t'((17'h1 << k) - 17'h1);
    return (cnt & mask) == mask;
  endfunction : tap_hit

  // Tap exponent of the third clock
  function automatic logic [3:0] exp_c(input logic [1:0] code);
    logic [3:0] e;
    case (code)
      2'h0: e = `TOC_C_EXP_0;
      2'h1: e = `TOC_C_EXP_1;
      2'h2: e = `TOC_C_EXP_2;
      default: e = `TOC_C_EXP_3;
    endcase
    return e;
  endfunction : exp_c

  // Tap exponent of the fourth clock
  function automatic logic [3:0] exp_d(input logic [1:0] code);
    logic [3:0] e;
    case (code)
      2'h0: e = `TOC_D_EXP_0;
      2'h1: e = `TOC_D_EXP_1;
      2'h2: e = `TOC_D_EXP_2;
      default: e = `TOC_D_EXP_3;
    endcase
    return e;
  endfunction : exp_d

  toc_prescale_s prescale_select_reg_unit0_q;
  logic unit_clock_enable_q;
  toc_count_t div_cnt_q;
  toc_count_t div_cnt_d;
  toc_clocks_s clocks_q;
  toc_clocks_s clocks_d;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic [NUM_CH-1:0] channel_run_status_reg;
  logic hit_prescale;
  logic hit_run;
  logic hit_ctrl;
  logic mapped;
  logic wr_access;
  logic full_half;
  logic wr_prescale;

  // Address decode on word-aligned byte addresses
  assign hit_prescale = (PADDR_I[23:2] == `TOC_IDX_PRESCALE) && (PADDR_I[1:0] == 2'h0);
  assign hit_run = (PADDR_I[23:2] == `TOC_IDX_RUN_STATUS) && (PADDR_I[1:0] == 2'h0);
  assign hit_ctrl = (PADDR_I[23:2] == `TOC_IDX_UNIT_CTRL) && (PADDR_I[1:0] == 2'h0);
  assign mapped = hit_prescale || hit_run || hit_ctrl;
  assign wr_access = PSEL_I && PENABLE_I && PWRITE_I;
  assign full_half = (PSTRB_I[1:0] == 2'h3);
  assign wr_prescale = wr_access && hit_prescale && full_half && unit_clock_enable_q; // see RULE11 see RULE18

  // Zero-wait slave; errors on unmapped, read-only or partial select-register writes
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && (!mapped || (PWRITE_I && hit_run) ||
                     (PWRITE_I && hit_prescale && !full_half)); // see RULE11
  assign PRDATA_O = prdata_q;

  // Run status view, cleared while the unit is off
  assign channel_run_status_reg = CHANNEL_RUN_STATUS_I & {NUM_CH{unit_clock_enable_q}}; // see RULE19

  // Run status is read-only and refuses writes
  a_status_readonly: assert property ( // see RULE19
    @(posedge CLK_I) disable iff (!RST_N_I)
    (PSEL_I && PENABLE_I && PWRITE_I && hit_run) |-> PSLVERR_O)
    else $error("write to run status not refused");

  // Read data mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_prescale) begin
      rd_mux = {16'h0000, prescale_select_reg_unit0_q};
    end else if (hit_run) begin
      rd_mux = {{(32-NUM_CH){1'b0}}, channel_run_status_reg}; // see RULE19
    end else if (hit_ctrl) begin
      rd_mux = {31'h0000_0000, unit_clock_enable_q};
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      prdata_q <= 32'h0000_0000;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      prdata_q <= rd_mux;
    end
  end

  // Unit clock enable register
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      unit_clock_enable_q <= `TOC_RST_UNIT_CTRL;
    end else if (wr_access && hit_ctrl && PSTRB_I[0]) begin
      unit_clock_enable_q <= PWDATA_I[`TOC_UNIT_EN_BIT];
    end
  end

  // Unit enable follows its bit of a control write
  a_enable_write: assert property ( // see RULE18
    @(posedge CLK_I) disable iff (!RST_N_I)
    (wr_access && hit_ctrl && PSTRB_I[0]) |=> (unit_clock_enable_q == $past(PWDATA_I[`TOC_UNIT_EN_BIT])))
    else $error("unit enable write not taken");

  // Prescale select register, reserved bits forced to zero
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      prescale_select_reg_unit0_q <= `TOC_RST_PRESCALE; // see RULE12
    end else if (!unit_clock_enable_q) begin
      prescale_select_reg_unit0_q <= `TOC_RST_PRESCALE; // see RULE18
    end else if (wr_prescale) begin
      prescale_select_reg_unit0_q <= PWDATA_I[15:0] & `TOC_PRESCALE_WMASK; // see RULE14 see RULE11
    end
  end

  // Writes while the unit is off leave the register cleared
  a_disabled_write: assert property ( // see RULE18
    @(posedge CLK_I) disable iff (!RST_N_I)
    (wr_access && hit_prescale && !unit_clock_enable_q) |=>
      (prescale_select_reg_unit0_q == `TOC_RST_PRESCALE))
    else $error("select register written while unit disabled");

  // Select register read back in the access cycle
  a_read_select: assert property ( // see RULE12
    @(posedge CLK_I) disable iff (!RST_N_I)
    (PSEL_I && !PENABLE_I && !PWRITE_I && hit_prescale) |=>
      (PRDATA_O == {16'h0000, $past(prescale_select_reg_unit0_q)}))
    else $error("select register read mismatch");

  assign PRESCALE_SELECT_REG_O = prescale_select_reg_unit0_q;
  assign UNIT_CLOCK_ENABLE_O = unit_clock_enable_q;

  // Free-running divider, cleared to zero while the unit is off
  assign div_cnt_d = unit_clock_enable_q ? div_cnt_q + 16'h0001 : `TOC_RST_COUNT;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      div_cnt_q <= `TOC_RST_COUNT;
    end else begin
      div_cnt_q <= div_cnt_d;
    end
  end

  // Divider cleared while the unit is off
  a_counter_held: assert property ( // see RULE18
    @(posedge CLK_I) disable iff (!RST_N_I)
    !unit_clock_enable_q |=> (div_cnt_q == `TOC_RST_COUNT))
    else $error("divider runs while unit disabled");

  // Divider advances by one each enabled cycle
  a_counter_step: assert property ( // see RULE5
    @(posedge CLK_I) disable iff (!RST_N_I)
    unit_clock_enable_q |=> (div_cnt_q == $past(div_cnt_q) + 16'h0001))
    else $error("divider skipped a count");

  // Tap selection for each shared clock, all silent while the unit is off
  always_comb begin
    clocks_d = '0;
    if (unit_clock_enable_q) begin // see RULE18
      clocks_d.shared_op_clock_a =
        tap_hit(div_cnt_q, prescale_select_reg_unit0_q.clock_a_divider_field); // see RULE1 see RULE5
      clocks_d.shared_op_clock_b =
        tap_hit(div_cnt_q, prescale_select_reg_unit0_q.clock_b_divider_field); // see RULE2 see RULE5
      clocks_d.shared_op_clock_c =
        tap_hit(div_cnt_q, exp_c(prescale_select_reg_unit0_q.clock_c_divider_field)); // see RULE3 see RULE6
      clocks_d.shared_op_clock_d =
        tap_hit(div_cnt_q, exp_d(prescale_select_reg_unit0_q.clock_d_divider_field)); // see RULE4 see RULE7 see RULE8
    end
  end

  // One-cycle enable pulses from flip-flops
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      clocks_q <= '0;
    end else begin
      clocks_q <= clocks_d; // see RULE13
    end
  end

  assign SHARED_OP_CLOCK_A_O = clocks_q.shared_op_clock_a;
  assign SHARED_OP_CLOCK_B_O = clocks_q.shared_op_clock_b;
  assign SHARED_OP_CLOCK_C_O = clocks_q.shared_op_clock_c; // see RULE3
  assign SHARED_OP_CLOCK_D_O = clocks_q.shared_op_clock_d; // see RULE4

  // No pulses while the unit is off
  a_disabled_quiet: assert property ( // see RULE18
    @(posedge CLK_I) disable iff (!RST_N_I)
    !unit_clock_enable_q |=>
      ({SHARED_OP_CLOCK_D_O, SHARED_OP_CLOCK_C_O, SHARED_OP_CLOCK_B_O, SHARED_OP_CLOCK_A_O} == 4'h0))
    else $error("shared clock pulse while unit disabled");

  // Register clear while disabled
  a_disabled_clear: assert property ( // see RULE18
    @(posedge CLK_I) disable iff (!RST_N_I)
    !unit_clock_enable_q |=> (prescale_select_reg_unit0_q == `TOC_RST_PRESCALE))
    else $error("select register not cleared while unit disabled");

  // Lower-halfword write (both low strobes) updates all fields
  a_write_fields: assert property ( // see RULE11
    @(posedge CLK_I) disable iff (!RST_N_I)
    (wr_access && hit_prescale && full_half && unit_clock_enable_q) |=>
      (prescale_select_reg_unit0_q == ($past(PWDATA_I[15:0]) & `TOC_PRESCALE_WMASK)))
    else $error("select register write not taken");

  // Partial write ignored and flagged
  a_partial_ignored: assert property ( // see RULE11
    @(posedge CLK_I) disable iff (!RST_N_I)
    (wr_access && hit_prescale && !full_half) |-> PSLVERR_O ##1 $stable(prescale_select_reg_unit0_q))
    else $error("partial write altered select register");

  // Reserved bits read zero
  a_reserved_zero: assert property ( // see RULE14
    @(posedge CLK_I) disable iff (!RST_N_I)
    (prescale_select_reg_unit0_q[15:14] == 2'h0) && (prescale_select_reg_unit0_q[11:10] == 2'h0))
    else $error("reserved select bits set");

  // Undivided first clock is high every cycle
  a_full_rate: assert property ( // see RULE5 see RULE12
    @(posedge CLK_I) disable iff (!RST_N_I)
    (unit_clock_enable_q && prescale_select_reg_unit0_q.clock_a_divider_field == 4'h0) |=> SHARED_OP_CLOCK_A_O)
    else $error("undivided clock a missing a pulse");

  // Divided pulse lasts one cycle
  a_pulse_width: assert property ( // see RULE13
    @(posedge CLK_I) disable iff (!RST_N_I)
    (SHARED_OP_CLOCK_B_O && prescale_select_reg_unit0_q.clock_b_divider_field != 4'h0 &&
     $stable(prescale_select_reg_unit0_q.clock_b_divider_field)) |=> !SHARED_OP_CLOCK_B_O)
    else $error("clock b pulse wider than one cycle");

  // Third clock at divide by two alternates
  a_c_half_rate: assert property ( // see RULE6
    @(posedge CLK_I) disable iff (!RST_N_I)
    (SHARED_OP_CLOCK_C_O && unit_clock_enable_q && prescale_select_reg_unit0_q.clock_c_divider_field == 2'h0)
    ##1 (unit_clock_enable_q && prescale_select_reg_unit0_q.clock_c_divider_field == 2'h0)
    |-> !SHARED_OP_CLOCK_C_O ##1 SHARED_OP_CLOCK_C_O)
    else $error("clock c not at half rate");

  // Fourth clock stays low for at least eight cycles after each pulse
  a_d_gap: assert property ( // see RULE7 see RULE8
    @(posedge CLK_I) disable iff (!RST_N_I)
    SHARED_OP_CLOCK_D_O |=> !SHARED_OP_CLOCK_D_O [*8])
    else $error("clock d pulses too close");

  // Divided first clock pulse lasts one cycle
  a_a_width: assert property ( // see RULE13
    @(posedge CLK_I) disable iff (!RST_N_I)
    (SHARED_OP_CLOCK_A_O && prescale_select_reg_unit0_q.clock_a_divider_field != 4'h0 &&
     $stable(prescale_select_reg_unit0_q.clock_a_divider_field)) |=> !SHARED_OP_CLOCK_A_O)
    else $error("clock a pulse wider than one cycle");

  // Third clock never stays high two cycles
  a_c_width: assert property ( // see RULE13
    @(posedge CLK_I) disable iff (!RST_N_I)
    SHARED_OP_CLOCK_C_O |=> !SHARED_OP_CLOCK_C_O)
    else $error("clock c pulse wider than one cycle");

  // Second clock at divide by two alternates
  a_b_half_rate: assert property ( // see RULE5
    @(posedge CLK_I) disable iff (!RST_N_I)
    (SHARED_OP_CLOCK_B_O && unit_clock_enable_q && prescale_select_reg_unit0_q.clock_b_divider_field == 4'h1 &&
     $stable(prescale_select_reg_unit0_q.clock_b_divider_field))
    ##1 (unit_clock_enable_q && prescale_select_reg_unit0_q.clock_b_divider_field == 4'h1)
    |-> !SHARED_OP_CLOCK_B_O ##1 SHARED_OP_CLOCK_B_O)
    else $error("clock b not at half rate");

  // Third clock pulses only on its smallest tap boundary
  a_c_min_tap: assert property ( // see RULE6
    @(posedge CLK_I) disable iff (!RST_N_I)
    SHARED_OP_CLOCK_C_O |-> tap_hit($past(div_cnt_q), `TOC_C_EXP_0))
    else $error("clock c pulse off its tap");

  // Fourth clock pulses only on its smallest tap boundary
  a_d_min_tap: assert property ( // see RULE7
    @(posedge CLK_I) disable iff (!RST_N_I)
    SHARED_OP_CLOCK_D_O |-> tap_hit($past(div_cnt_q), `TOC_D_EXP_0))
    else $error("clock d pulse off its tap");

  // Select register is clear at the first edge after reset
  a_reset_clear: assert property ( // see RULE12
    @(posedge CLK_I)
    !$past(RST_N_I) |-> (prescale_select_reg_unit0_q == `TOC_RST_PRESCALE))
    else $error("select register not cleared by reset");

  // Reset leaves the unit off
  a_reset_off: assert property ( // see RULE18
    @(posedge CLK_I)
    !$past(RST_N_I) |-> !unit_clock_enable_q)
    else $error("unit enabled straight after reset");

  // Status read shows channel run state
  a_status_view: assert property ( // see RULE19
    @(posedge CLK_I) disable iff (!RST_N_I)
    (PSEL_I && !PENABLE_I && !PWRITE_I && hit_run) |=>
      (PRDATA_O == {{(32-NUM_CH){1'b0}}, $past(CHANNEL_RUN_STATUS_I & {NUM_CH{unit_clock_enable_q}})}))
    else $error("run status read mismatch");

endmodule : toc_prescaler

// *** toc_regs.svh ***
`ifndef TOC_REGS_SVH
`define TOC_REGS_SVH

// Register indices; byte address is four times the index
`define TOC_IDX_PRESCALE 22'h0f01b6
`define TOC_IDX_RUN_STATUS 22'h0f01b8
`define TOC_IDX_UNIT_CTRL 22'h0f01ba

// Reset values
`define TOC_RST_PRESCALE 16'h0000
`define TOC_RST_UNIT_CTRL 1'b0
`define TOC_RST_COUNT 16'h0000

// Writable bits of the prescale select register
`define TOC_PRESCALE_WMASK 16'h33ff

// Fixed tap exponents of the third and fourth clocks
`define TOC_C_EXP_0 4'h1
`define TOC_C_EXP_1 4'h2
`define TOC_C_EXP_2 4'h4
`define TOC_C_EXP_3 4'h6
`define TOC_D_EXP_0 4'h8
`define TOC_D_EXP_1 4'ha
`define TOC_D_EXP_2 4'hc
`define TOC_D_EXP_3 4'he

// Field positions
`define TOC_UNIT_EN_BIT 0

`endif

// *** toc_pkg.sv ***
package toc_pkg;

  // Layout of the prescale select register
  typedef struct packed {
    logic [1:0] rsv_hi;
    logic [1:0] clock_d_divider_field;
    logic [1:0] rsv_mid;
    logic [1:0] clock_c_divider_field;
    logic [3:0] clock_b_divider_field;
    logic [3:0] clock_a_divider_field;
  } toc_prescale_s;

  // One-cycle enables of the four shared operation clocks
  typedef struct packed {
    logic shared_op_clock_d;
    logic shared_op_clock_c;
    logic shared_op_clock_b;
    logic shared_op_clock_a;
  } toc_clocks_s;

  typedef logic [15:0] toc_count_t;

endpackage : toc_pkg

// *** timer_operation_clock_prescaler_tb.sv ***
`timescale 1ns/1ps
`include "toc_regs.svh"
module timer_operation_clock_prescaler_tb;
  import toc_pkg::*;
  localparam logic [23:0] A_PS = 24'(`TOC_IDX_PRESCALE * 4);
  localparam logic [23:0] A_RS = 24'(`TOC_IDX_RUN_STATUS * 4);
  localparam logic [23:0] A_UC = 24'(`TOC_IDX_UNIT_CTRL * 4);
  // Clock a taps; the undivided tap is only timed, no channel interrupt is relied on
  localparam int KA[4] = '{0, 5, 11, 3};
  localparam int KB[4] = '{1, 9, 4, 7};
  localparam int KC[4] = '{1, 2, 4, 6};
  localparam int KD[4] = '{8, 10, 12, 14};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [23:0] paddr = 24'h000000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic [7:0] run = 8'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic unit_en;
  logic [15:0] ps_reg;
  logic [3:0] clk_v;
  logic [33:0] q[$];
  logic [33:0] e;
  logic [15:0] v;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;

  // Peripheral clock, 100 ns period
  always #50 clk = ~clk;

  toc_prescaler u_toc_prescaler (
    .CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .CHANNEL_RUN_STATUS_I(run), .PRESCALE_SELECT_REG_O(ps_reg),
    .UNIT_CLOCK_ENABLE_O(unit_en), .SHARED_OP_CLOCK_A_O(clk_v[0]), .SHARED_OP_CLOCK_B_O(clk_v[1]),
    .SHARED_OP_CLOCK_C_O(clk_v[2]), .SHARED_OP_CLOCK_D_O(clk_v[3])
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task finish_test();
    if (miscompares == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  // One APB transfer; the expected answer is queued for the monitor
  task apb(input logic wr, input logic [23:0] a, input logic [31:0] d, input logic [3:0] s,
           input logic err, input logic [31:0] x);
    q.push_back({~wr, err, x});
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Measures pulse width and spacing of one shared clock
  task period(input int sel, input int k);
    int n;
    n = 0;
    @(negedge clk);
    while (clk_v[sel] !== 1'b1 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    check(32'(clk_v[sel]), 32'(k == 0));
    n = 1;
    while (clk_v[sel] !== 1'b1 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    check(32'(n), 32'(1 << k));
  endtask : period

  // Monitor: compares each completed transfer with the oldest note
  always @(negedge clk) begin
    if (psel && penable && pready === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      check({31'h0, pslverr}, {31'h0, e[32]});
      if (e[33]) begin
        check(prdata, e[31:0]);
      end
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      finish_test();
    end
  end

  // Main sequence
  initial begin
    void'($urandom(32'hb799));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check({16'h0, ps_reg}, 32'h0);
    apb(1'b0, A_PS, 32'h0, 4'h0, 1'b0, 32'h0);
    apb(1'b1, A_PS, 32'h00000321, 4'h3, 1'b0, 32'h0);
    apb(1'b0, A_PS, 32'h0, 4'h0, 1'b0, 32'h0);
    run <= 8'($urandom);
    apb(1'b0, A_RS, 32'h0, 4'h0, 1'b0, 32'h0);
    apb(1'b1, A_UC, 32'h1, 4'h1, 1'b0, 32'h0);
    @(negedge clk);
    check({31'h0, unit_en}, 32'h1);
    apb(1'b0, A_RS, 32'h0, 4'h0, 1'b0, {24'h0, run});
    apb(1'b1, A_RS, 32'hff, 4'hf, 1'b1, 32'h0);
    apb(1'b0, 24'h000010, 32'h0, 4'h0, 1'b1, 32'h0);
    // Every channel stopped before any clock is reselected
    run <= 8'h00;
    for (int i = 0; i < 4; i++) begin
      v = {2'b00, 2'(i), 2'b00, 2'(i), 4'(KB[i]), 4'(KA[i])};
      apb(1'b1, A_PS, {16'h0, v}, 4'h3, 1'b0, 32'h0);
      apb(1'b0, A_PS, 32'h0, 4'h0, 1'b0, {16'h0, v});
      @(negedge clk);
      check({16'h0, ps_reg}, {16'h0, v});
      period(0, KA[i]);
      period(1, KB[i]);
      period(2, KC[i]);
      period(3, KD[i]);
    end
    apb(1'b1, A_PS, $urandom & 32'h33ff, 4'h1, 1'b1, 32'h0);
    apb(1'b0, A_PS, 32'h0, 4'h0, 1'b0, {16'h0, v});
    apb(1'b1, A_UC, 32'h0, 4'h1, 1'b0, 32'h0);
    apb(1'b0, A_PS, 32'h0, 4'h0, 1'b0, 32'h0);
    repeat (40) begin
      @(negedge clk);
      check({28'h0, clk_v}, 32'h0);
      check({31'h0, unit_en}, 32'h0);
    end
    finish_test();
  end
endmodule : timer_operation_clock_prescaler_tb
